// ===== logic/ctb_regs.svh
`ifndef CTB_REGS_SVH
`define CTB_REGS_SVH

// ----------------------------------------------------------------
// Register map, word index = byte address bits 8:2
// ----------------------------------------------------------------
`define CTB_ALIAS_BUF 2'h3
`define CTB_IDX_CCR 7'h40
`define CTB_IDX_TEC 7'h41
`define CTB_IDX_IST 7'h42
`define CTB_IDX_IMSK 7'h43

// ----------------------------------------------------------------
// Fields inside one buffer window
// ----------------------------------------------------------------
`define CTB_F_CTRL 4'h0
`define CTB_F_IDL 4'h2
`define CTB_F_LEN 4'h5
`define CTB_F_LAST 4'hd
`define CTB_OFF_IDH 4'h0
`define CTB_OFF_IDL 4'h1
`define CTB_OFF_EXH 4'h2
`define CTB_OFF_EXL 4'h3
`define CTB_OFF_LEN 4'h4
`define CTB_OFF_DAT0 4'h5
`define CTB_OFF_LAST 4'hc
`define CTB_BUF_BYTES 6'h0d
`define CTB_MEM_DEPTH 39

// ----------------------------------------------------------------
// Bits and masks
// ----------------------------------------------------------------
`define CTB_CB_REQ 3
`define CTB_IDL_MASK 8'heb
`define CTB_LEN_MASK 8'h4f
`define CTB_EXT_BIT 3
`define CTB_RTR_BIT 6
`define CTB_WIN_TX0 4'h8
`define CTB_MODE_NORMAL 3'h0
`define CTB_MODE_LOOP 3'h2
`define CTB_CCR_RESET 8'h80
`define CTB_DLC_MAX 4'h8

// ----------------------------------------------------------------
// Transmit error counter
// ----------------------------------------------------------------
`define CTB_TEC_STEP 8'h08
`define CTB_TEC_OVF_AT 8'hf8
`define CTB_TEC_MAX 8'hff
`define CTB_IDLE_SEQ_LAST 8'h7f

`endif

// ===== logic/ctb_pkg.sv
package ctb_pkg;

  typedef logic [7:0] ctb_byte_t;
  typedef logic [3:0] ctb_dlc_t;

  typedef enum logic [2:0]
  {
    LD_IDLE = 3'b001,
    LD_READ = 3'b010,
    LD_SEND = 3'b100
  } ctb_ld_state_t;

endpackage

// ===== logic/ctb_mem_if.sv
`timescale 1ns/1ps

interface ctb_mem_if;
  logic wr_en;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic [5:0] rd_a_addr;
  logic [7:0] rd_a_data;
  logic [5:0] rd_b_addr;
  logic [7:0] rd_b_data;

  modport mem
  (
    input wr_en, wr_addr, wr_data, rd_a_addr, rd_b_addr,
    output rd_a_data, rd_b_data
  );
  modport ctl
  (
    output wr_en, wr_addr, wr_data, rd_a_addr, rd_b_addr,
    input rd_a_data, rd_b_data
  );
endinterface

// ===== logic/ctb_mem.sv
`timescale 1ns/1ps
`include "ctb_regs.svh"

module ctb_mem
(
  input wire logic clock_in,
  ctb_mem_if.mem m
);
  import ctb_pkg::*;

  // Contents are not reset; software loads every field it relies on.
  ctb_byte_t mem_q [`CTB_MEM_DEPTH];
  ctb_byte_t rd_a_q;
  ctb_byte_t rd_b_q;

  always_ff @(posedge clock_in)
  begin
    if (m.wr_en)
    begin
      mem_q[m.wr_addr] <= m.wr_data;
    end
  end

  // Two read ports so the frame loader never stalls the bus.
  always_ff @(posedge clock_in)
  begin
    rd_a_q <= mem_q[m.rd_a_addr];
    rd_b_q <= mem_q[m.rd_b_addr];
  end

  assign m.rd_a_data = rd_a_q;
  assign m.rd_b_data = rd_b_q;
endmodule

// ===== logic/ctb_tec.sv
`timescale 1ns/1ps
`include "ctb_regs.svh"

module ctb_tec
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic add_err_in,
  input wire logic sub_ok_in,
  input wire logic idle11_in,
  output ctb_pkg::ctb_byte_t count_out,
  output logic bus_off_out,
  output logic off_enter_out,
  output logic off_exit_out
);
  import ctb_pkg::*;

  ctb_byte_t cnt_q;
  ctb_byte_t seq_q;
  logic off_q;
  logic enter_q;
  logic exit_q;

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      cnt_q <= 8'h00;
      off_q <= 1'b0;
      seq_q <= 8'h00;
      enter_q <= 1'b0;
      exit_q <= 1'b0;
    end
    else
    begin
      enter_q <= 1'b0;
      exit_q <= 1'b0;
      if (!off_q)
      begin
        seq_q <= 8'h00;
        if (add_err_in)
        begin
          if (cnt_q >= `CTB_TEC_OVF_AT)
          begin
            cnt_q <= `CTB_TEC_MAX;
            off_q <= 1'b1;
            enter_q <= 1'b1;
          end
          else
          begin
            cnt_q <= cnt_q + `CTB_TEC_STEP;
          end
        end
        else if (sub_ok_in && cnt_q != 8'h00)
        begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
      else if (idle11_in)
      begin
        if (seq_q == `CTB_IDLE_SEQ_LAST)
        begin
          cnt_q <= 8'h00;
          off_q <= 1'b0;
          seq_q <= 8'h00;
          exit_q <= 1'b1;
        end
        else
        begin
          seq_q <= seq_q + 8'h01;
        end
      end
    end
  end

  assign count_out = cnt_q;
  assign bus_off_out = off_q;
  assign off_enter_out = enter_q;
  assign off_exit_out = exit_q;
endmodule

// ===== logic/ctb_top.sv
`timescale 1ns/1ps
`include "ctb_regs.svh"

// How it works
// - Identifier-high byte gives standard bits 10:3 or extended bits 28:21.
// - Identifier-low bits 7:5 give standard 2:0 or extended 20:18.
// - Extended enable bit 3 set sends extended id, standard field on top.
// - Extended enable clear sends standard id only, low 18 bits ignored.
// - Extended bits 17:0 come from id-low 1:0 and both extended bytes.
// - Each buffer has eight read/write data byte registers, index 0 to 7.
// - Frame remote request bit equals length-control bit 6.
// - Length codes 0 to 8 are valid; 9 to 15 are reserved.
// - Unimplemented id-low and length-control bits read as zero.
// - Read-only 8-bit transmit error counter; overflow enters bus-off.
// - In bus-off, 128 runs of 11 recessive bits clear the counter.
// - Transmission only in normal or loopback mode.
// - Window select 1000 maps receive buffer zero addresses to buffer 0.
// - Pending buffer is read-only; clearing the request asks an abort.
// - Request bit clears itself after a successful send.
module ctb_top
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [8:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic irq_out,
  output logic tx_valid_out,
  output logic [1:0] tx_buf_out,
  output logic [28:0] tx_id_out,
  output logic tx_ext_out,
  output logic tx_rtr_out,
  output ctb_pkg::ctb_dlc_t tx_dlc_out,
  output ctb_pkg::ctb_dlc_t tx_bytes_out,
  output logic [63:0] tx_data_out,
  output logic tx_abort_out,
  output logic bus_off_out,
  input wire logic tx_done_in,
  input wire logic tx_bus_err_in,
  input wire logic tx_lost_arb_in,
  input wire logic idle11_in
);
  import ctb_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] mem_addr(input logic [1:0] b,
                                          input logic [3:0] off);
    mem_addr = 6'({4'h0, b} * `CTB_BUF_BYTES) + {2'h0, off};
  endfunction

  // Highest priority wins; on a tie the higher buffer number goes first.
  function automatic logic [2:0] pick(input logic [2:0] c,
                                      input logic [5:0] p);
    logic found;
    logic [1:0] best;
    logic [1:0] sel;
    found = 1'b0;
    best = 2'h0;
    sel = 2'h0;
    for (int i = 0; i < 3; i++)
    begin
      if (c[i] && (!found || p[2*i +: 2] >= best))
      begin
        found = 1'b1;
        best = p[2*i +: 2];
        sel = 2'(i);
      end
    end
    pick = {found, sel};
  endfunction

  function automatic ctb_dlc_t dlc_bytes(input ctb_dlc_t code);
    dlc_bytes = (code > `CTB_DLC_MAX) ? `CTB_DLC_MAX : code;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [6:0] idx;
  logic [3:0] fld;
  logic [1:0] buf_n;
  logic win_ok;
  logic is_buf;
  logic is_mem;
  logic start;
  logic wr_now;
  logic pend_q;
  logic ack_q;
  logic [31:0] dat_q;
  ctb_byte_t ccr_q;
  ctb_byte_t rd_byte;
  ctb_byte_t wr_byte;
  logic [2:0] req_q;
  logic [2:0] abt_q;
  logic [2:0] abq_q;
  logic [2:0] done_q;
  logic [2:0] larb_q;
  logic [2:0] err_q;
  logic [5:0] pri_q;
  logic [4:0] ist_q;
  logic [4:0] msk_q;
  logic [4:0] ist_set;
  logic [2:0] wr_ctl;
  logic [2:0] done_ev;
  logic [2:0] fail_ev;
  logic [2:0] busy;
  logic [2:0] choice;
  ctb_ld_state_t st_q;
  logic [1:0] act_q;
  logic [3:0] cnt_q;
  logic [3:0] rd_off_q;
  logic rd_vld_q;
  ctb_byte_t frm_q [13];
  logic mode_ok;
  logic off_enter;
  logic off_exit;
  logic frame_end;
  ctb_byte_t tec;
  ctb_byte_t idh;
  ctb_byte_t idl;
  logic ext;

  ctb_mem_if m();

  ctb_mem u_mem
  (
    .clock_in(clock_in),
    .m(m.mem)
  );

  ctb_tec u_tec
  (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .add_err_in(st_q == LD_SEND && tx_bus_err_in),
    .sub_ok_in(|done_ev),
    .idle11_in(idle11_in),
    .count_out(tec),
    .bus_off_out(bus_off_out),
    .off_enter_out(off_enter),
    .off_exit_out(off_exit)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign idx = wb_adr_in[8:2];
  assign fld = idx[3:0];
  assign win_ok = (ccr_q[3:0] == `CTB_WIN_TX0);
  assign buf_n = (idx[5:4] == `CTB_ALIAS_BUF) ? 2'h0 : idx[5:4];
  assign is_buf = !idx[6] && (fld <= `CTB_F_LAST) &&
                  (idx[5:4] != `CTB_ALIAS_BUF || win_ok);
  assign is_mem = is_buf && (fld != `CTB_F_CTRL);

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  assign start = wb_cyc_in && wb_stb_in && !pend_q && !ack_q;
  assign wr_now = pend_q && wb_we_in && wb_sel_in[0];

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      pend_q <= 1'b0;
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      pend_q <= start;
      ack_q <= pend_q;
      if (pend_q)
      begin
        dat_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = dat_q;

  always_comb
  begin
    wr_byte = wb_dat_in[7:0];
    if (fld == `CTB_F_IDL)
    begin
      wr_byte = wb_dat_in[7:0] & `CTB_IDL_MASK;
    end
    else if (fld == `CTB_F_LEN)
    begin
      wr_byte = wb_dat_in[7:0] & `CTB_LEN_MASK;
    end
  end

  // A pending buffer takes no writes, so the frame cannot change under
  // the loader.
  assign m.wr_en = wr_now && is_mem && !req_q[buf_n];
  assign m.wr_addr = mem_addr(buf_n, fld - 4'h1);
  assign m.wr_data = wr_byte;
  assign m.rd_a_addr = mem_addr(buf_n, fld - 4'h1);

  always_comb
  begin
    rd_byte = 8'h00;
    if (is_buf && fld == `CTB_F_CTRL)
    begin
      rd_byte = {done_q[buf_n], abt_q[buf_n], larb_q[buf_n], err_q[buf_n],
                 req_q[buf_n], 1'b0, pri_q[2*buf_n +: 2]};
    end
    else if (is_mem)
    begin
      rd_byte = m.rd_a_data;
    end
    else if (idx == `CTB_IDX_CCR)
    begin
      rd_byte = ccr_q;
    end
    else if (idx == `CTB_IDX_TEC)
    begin
      rd_byte = tec;
    end
    else if (idx == `CTB_IDX_IST)
    begin
      rd_byte = {3'h0, ist_q};
    end
    else if (idx == `CTB_IDX_IMSK)
    begin
      rd_byte = {3'h0, msk_q};
    end
  end

  // ----------------------------------------------------------------
  // Controller control, interrupt status and mask
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      ccr_q <= `CTB_CCR_RESET;
    end
    else if (wr_now && idx == `CTB_IDX_CCR)
    begin
      ccr_q <= wb_dat_in[7:0];
    end
  end

  assign ist_set = {off_exit, off_enter, done_ev};

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      ist_q <= 5'h00;
      msk_q <= 5'h00;
    end
    else
    begin
      if (wr_now && idx == `CTB_IDX_IST)
      begin
        ist_q <= (ist_q & ~wb_dat_in[4:0]) | ist_set;
      end
      else
      begin
        ist_q <= ist_q | ist_set;
      end
      if (wr_now && idx == `CTB_IDX_IMSK)
      begin
        msk_q <= wb_dat_in[4:0];
      end
    end
  end

  assign irq_out = |(ist_q & msk_q);

  // ----------------------------------------------------------------
  // Per-buffer control
  // ----------------------------------------------------------------
  assign frame_end = tx_done_in || tx_bus_err_in || tx_lost_arb_in;

  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      wr_ctl[i] = wr_now && is_buf && fld == `CTB_F_CTRL &&
                  buf_n == 2'(i);
      busy[i] = st_q != LD_IDLE && act_q == 2'(i);
      done_ev[i] = st_q == LD_SEND && tx_done_in && act_q == 2'(i);
      fail_ev[i] = st_q == LD_SEND && !tx_done_in &&
                   (tx_bus_err_in || tx_lost_arb_in) && act_q == 2'(i);
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      req_q <= 3'h0;
      abq_q <= 3'h0;
      abt_q <= 3'h0;
      pri_q <= 6'h00;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (done_ev[i])
        begin
          req_q[i] <= 1'b0;
          abq_q[i] <= 1'b0;
        end
        else if (fail_ev[i] && abq_q[i])
        begin
          req_q[i] <= 1'b0;
          abq_q[i] <= 1'b0;
          abt_q[i] <= 1'b1;
        end
        else if (wr_ctl[i])
        begin
          if (req_q[i])
          begin
            if (!wb_dat_in[`CTB_CB_REQ])
            begin
              if (busy[i])
              begin
                abq_q[i] <= 1'b1;
              end
              else
              begin
                req_q[i] <= 1'b0;
                abt_q[i] <= 1'b1;
              end
            end
          end
          else
          begin
            req_q[i] <= wb_dat_in[`CTB_CB_REQ];
            pri_q[2*i +: 2] <= wb_dat_in[1:0];
            if (wb_dat_in[`CTB_CB_REQ])
            begin
              abt_q[i] <= 1'b0;
            end
          end
        end
      end
    end
  end

  // Hardware setting of a status bit wins over a clear in the same cycle.
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      done_q <= 3'h0;
      larb_q <= 3'h0;
      err_q <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (wr_ctl[i] && !req_q[i] && wb_dat_in[`CTB_CB_REQ])
        begin
          done_q[i] <= 1'b0;
          larb_q[i] <= 1'b0;
          err_q[i] <= 1'b0;
        end
        if (done_ev[i])
        begin
          done_q[i] <= 1'b1;
        end
        if (fail_ev[i] && tx_lost_arb_in)
        begin
          larb_q[i] <= 1'b1;
        end
        if (fail_ev[i] && tx_bus_err_in)
        begin
          err_q[i] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame loader
  // ----------------------------------------------------------------
  assign mode_ok = ccr_q[7:5] == `CTB_MODE_NORMAL ||
                   ccr_q[7:5] == `CTB_MODE_LOOP;
  assign choice = pick(req_q & ~abq_q, pri_q);
  assign m.rd_b_addr = mem_addr(act_q, cnt_q);

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      st_q <= LD_IDLE;
      act_q <= 2'h0;
      cnt_q <= 4'h0;
    end
    else
    begin
      unique case (st_q)
        LD_IDLE:
        begin
          cnt_q <= 4'h0;
          if (choice[2] && mode_ok && !bus_off_out)
          begin
            act_q <= choice[1:0];
            st_q <= LD_READ;
          end
        end
        LD_READ:
        begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == `CTB_OFF_LAST)
          begin
            st_q <= LD_SEND;
          end
        end
        LD_SEND:
        begin
          if (frame_end)
          begin
            st_q <= LD_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      rd_vld_q <= 1'b0;
      rd_off_q <= 4'h0;
    end
    else
    begin
      rd_vld_q <= st_q == LD_READ;
      rd_off_q <= cnt_q;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rd_vld_q)
    begin
      frm_q[rd_off_q] <= m.rd_b_data;
    end
  end

  // ----------------------------------------------------------------
  // Frame fields toward the protocol engine
  // ----------------------------------------------------------------
  assign idh = frm_q[`CTB_OFF_IDH];
  assign idl = frm_q[`CTB_OFF_IDL];
  assign ext = idl[`CTB_EXT_BIT];

  always_comb
  begin
    if (ext)
    begin
      tx_id_out = {idh, idl[7:5], idl[1:0],
                   frm_q[`CTB_OFF_EXH], frm_q[`CTB_OFF_EXL]};
    end
    else
    begin
      tx_id_out = {18'h0_0000, idh, idl[7:5]};
    end
    for (int j = 0; j < 8; j++)
    begin
      tx_data_out[8*j +: 8] = frm_q[int'(`CTB_OFF_DAT0) + j];
    end
  end

  assign tx_ext_out = ext;
  assign tx_rtr_out = frm_q[`CTB_OFF_LEN][`CTB_RTR_BIT];
  assign tx_dlc_out = frm_q[`CTB_OFF_LEN][3:0];
  assign tx_bytes_out = dlc_bytes(frm_q[`CTB_OFF_LEN][3:0]);
  assign tx_buf_out = act_q;
  assign tx_valid_out = st_q == LD_SEND && !rd_vld_q;
  assign tx_abort_out = st_q == LD_SEND && abq_q[act_q];
endmodule

// ===== testbench/ctb_top_assertions.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Port checker for the transmit buffer block
// ----------------------------------------------------------------
module ctb_top_assertions
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic wb_stb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic tx_valid_out,
  input wire logic [28:0] tx_id_out,
  input wire logic tx_ext_out,
  input wire ctb_pkg::ctb_dlc_t tx_dlc_out,
  input wire ctb_pkg::ctb_dlc_t tx_bytes_out,
  input wire logic [63:0] tx_data_out,
  input wire logic bus_off_out,
  input wire logic tx_done_in,
  input wire logic tx_bus_err_in,
  input wire logic tx_lost_arb_in,
  input wire logic idle11_in
);
  import ctb_pkg::*;
  logic frame_end;
  assign frame_end = tx_done_in | tx_bus_err_in | tx_lost_arb_in;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_request;
    $rose(wb_stb_in);
  endsequence
  sequence s_answer;
    !wb_ack_out ##1 wb_ack_out;
  endsequence
  a_ack_timing: assert property (s_request |=> s_answer)
    else $error("bus answer not two cycles after request");
  a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("bus answer longer than one cycle");
  a_read_width: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_offer_hold: assert property (tx_valid_out && !frame_end |=> tx_valid_out)
    else $error("offer dropped without an end pulse");
  a_offer_ends: assert property (tx_valid_out && frame_end |=> !tx_valid_out)
    else $error("offer held after an end pulse");
  a_frame_stable: assert property (tx_valid_out && $past(tx_valid_out) |->
    $stable({tx_id_out, tx_ext_out, tx_dlc_out, tx_data_out}))
    else $error("offered frame changed");
  a_bytes_clamp: assert property (tx_valid_out |->
    tx_bytes_out == ((tx_dlc_out > 4'h8) ? 4'h8 : tx_dlc_out))
    else $error("byte count does not follow length code");
  a_std_upper: assert property (tx_valid_out && !tx_ext_out |->
    tx_id_out[28:11] == 18'h0)
    else $error("standard frame carries extended bits");
  a_offline_quiet: assert property (bus_off_out [*2] |-> !tx_valid_out)
    else $error("frame offered while bus-off");
  a_offline_exit: assert property ($fell(bus_off_out) |-> $past(idle11_in))
    else $error("bus-off left without idle sequence");
endmodule

bind ctb_top ctb_top_assertions i_ctb_top_assertions (.clock_in, .rst_n_in,
  .wb_stb_in, .wb_dat_out, .wb_ack_out, .tx_valid_out, .tx_id_out,
  .tx_ext_out, .tx_dlc_out, .tx_bytes_out, .tx_data_out, .bus_off_out,
  .tx_done_in, .tx_bus_err_in, .tx_lost_arb_in, .idle11_in);

// ===== testbench/ctb_engine_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Far-side engine: ends each offered frame with one pulse
// ----------------------------------------------------------------
module ctb_engine_model
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic tx_valid_in,
  input wire logic [1:0] mode_in,
  input wire logic slow_in,
  output logic done_out,
  output logic bus_err_out,
  output logic lost_arb_out
);
  logic [4:0] wait_q;
  logic hold_q;
  logic [2:0] end_q;
  logic fire;
  // The hold flag stops a second pulse while the offer is still falling.
  assign fire = tx_valid_in && !hold_q && wait_q == (slow_in ? 5'h14 : 5'h1);
  assign {lost_arb_out, bus_err_out, done_out} = end_q;
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in || !tx_valid_in)
    begin
      wait_q <= 5'h0;
      hold_q <= 1'b0;
    end
    else if (!hold_q)
    begin
      wait_q <= wait_q + 5'h1;
      hold_q <= fire;
    end
  end
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      end_q <= 3'h0;
    else
      end_q <= fire ? (3'h1 << mode_in) : 3'h0;
  end
endmodule

// ===== testbench/ctb_top_tb.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Bench: register bus tasks and scenario sequence
// ----------------------------------------------------------------
module ctb_top_tb;
  import ctb_pkg::*;
  logic clock_in, rst_n_in, wb_cyc_in, wb_stb_in, wb_we_in, idle11_in;
  logic [8:0] wb_adr_in;
  logic [3:0] wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out;
  logic wb_ack_out, irq_out, tx_valid_out, tx_ext_out, tx_rtr_out;
  logic tx_abort_out, bus_off_out, tx_done_in, tx_bus_err_in, tx_lost_arb_in;
  logic [1:0] tx_buf_out, eng_mode;
  logic [28:0] tx_id_out;
  ctb_dlc_t tx_dlc_out, tx_bytes_out;
  logic [63:0] tx_data_out, exp_data;
  logic [7:0] rd;
  logic eng_slow;
  int err_total, comparisons, cycles;

  initial
  begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end

  ctb_top i_ctb_top (.clock_in, .rst_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
    .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .irq_out,
    .tx_valid_out, .tx_buf_out, .tx_id_out, .tx_ext_out, .tx_rtr_out,
    .tx_dlc_out, .tx_bytes_out, .tx_data_out, .tx_abort_out, .bus_off_out,
    .tx_done_in, .tx_bus_err_in, .tx_lost_arb_in, .idle11_in);

  ctb_engine_model i_ctb_engine_model (.clock_in, .rst_n_in,
    .tx_valid_in(tx_valid_out), .mode_in(eng_mode), .slow_in(eng_slow),
    .done_out(tx_done_in), .bus_err_out(tx_bus_err_in),
    .lost_arb_out(tx_lost_arb_in));

  task automatic complete_run;
    if (err_total == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      complete_run();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits for the answer as long as it takes; only the cycle ceiling
  // ends a hung handshake.
  task automatic bus(input logic [6:0] idx, input logic we,
                     input logic [7:0] wd);
    @(posedge clock_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_sel_in <= 4'h1;
    wb_adr_in <= {idx, 2'b00};
    wb_dat_in <= {24'h0, wd};
    do
    begin
      @(posedge clock_in);
    end
    while (wb_ack_out !== 1'b1);
    check(wb_ack_out, 1'b1);
    rd = wb_dat_out[7:0];
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask

  task automatic wr(input logic [6:0] idx, input logic [7:0] wd);
    bus(idx, 1'b1, wd);
  endtask

  task automatic rd_chk(input logic [6:0] idx, input logic [7:0] exp);
    bus(idx, 1'b0, 8'h00);
    check(rd, exp);
  endtask

  task automatic poll(input logic [6:0] idx, input logic [7:0] exp);
    int n;
    n = 0;
    do
    begin
      bus(idx, 1'b0, 8'h00);
      n++;
    end
    while (rd[3] !== 1'b0 && n < 200);
    check(rd & 8'h88, exp);
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return tx_valid_out;
      1: return bus_off_out;
      default: return tx_lost_arb_in;
    endcase
  endfunction

  task automatic wait_on(input int k, input int lim);
    int n;
    n = 0;
    while (sig(k) !== 1'b1 && n < lim)
    begin
      @(posedge clock_in);
      n++;
    end
    check(sig(k), 1'b1);
  endtask

  task automatic idle_pulses(input int count);
    repeat (count)
    begin
      @(posedge clock_in);
      idle11_in <= 1'b1;
      @(posedge clock_in);
      idle11_in <= 1'b0;
    end
    @(posedge clock_in);
  endtask

  initial
  begin
    {rst_n_in, wb_cyc_in, wb_stb_in, wb_we_in, idle11_in, eng_slow} = 6'h0;
    {wb_adr_in, wb_dat_in, eng_mode} = '0;
    wb_sel_in = 4'h1;
    {err_total, comparisons, cycles} = '0;
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    rd_chk(7'h41, 8'h00);
    rd_chk(7'h40, 8'h80);
    wr(7'h20, 8'h08);
    repeat (40) @(posedge clock_in);
    check(tx_valid_out, 1'b0);
    wr(7'h20, 8'h00);
    rd_chk(7'h20, 8'h40);
    wr(7'h11, 8'ha5);
    wr(7'h12, 8'hff);
    wr(7'h13, 8'h3c);
    wr(7'h14, 8'h96);
    wr(7'h15, 8'hff);
    for (int m = 0; m < 8; m++)
    begin
      wr(7'h16 + m[6:0], 8'h30 + m[7:0]);
      exp_data[8*m +: 8] = 8'h30 + m[7:0];
    end
    for (int m = 0; m < 8; m++)
      rd_chk(7'h16 + m[6:0], exp_data[8*m +: 8]);
    rd_chk(7'h12, 8'heb);
    rd_chk(7'h15, 8'h4f);
    wr(7'h43, 8'h00);
    wr(7'h40, 8'h00);
    eng_slow <= 1'b1;
    wr(7'h10, 8'h08);
    wait_on(0, 100);
    check(tx_id_out, {8'ha5, 3'h7, 2'h3, 8'h3c, 8'h96});
    check(tx_ext_out, 1'b1);
    check(tx_rtr_out, 1'b1);
    check({tx_dlc_out, tx_bytes_out}, 8'hf8);
    check({tx_abort_out, tx_buf_out}, 3'h1);
    check(tx_data_out, exp_data);
    wr(7'h11, 8'h00);
    rd_chk(7'h11, 8'ha5);
    // An abort asked while offered is flagged; the later done still wins.
    wr(7'h10, 8'h00);
    check(tx_abort_out, 1'b1);
    poll(7'h10, 8'h80);
    rd_chk(7'h42, 8'h02);
    check(irq_out, 1'b0);
    wr(7'h43, 8'h02);
    check(irq_out, 1'b1);
    wr(7'h42, 8'h02);
    check(irq_out, 1'b0);
    // Buffer zero loaded only through the receive-buffer window.
    wr(7'h40, 8'h48);
    eng_slow <= 1'b0;
    eng_mode <= 2'h2;
    wr(7'h31, 8'h24);
    wr(7'h32, 8'h60);
    wr(7'h33, 8'hff);
    wr(7'h34, 8'hff);
    wr(7'h35, 8'h02);
    wr(7'h30, 8'h08);
    wait_on(0, 100);
    check(tx_id_out, 29'h123);
    check({tx_buf_out, tx_ext_out, tx_rtr_out, tx_bytes_out}, 8'h02);
    wait_on(2, 100);
    eng_mode <= 2'h0;
    poll(7'h30, 8'h80);
    rd_chk(7'h01, 8'h24);
    // Every retry fails until the counter saturates.
    wr(7'h40, 8'h00);
    eng_mode <= 2'h1;
    wr(7'h10, 8'h08);
    wait_on(1, 3000);
    eng_mode <= 2'h0;
    rd_chk(7'h41, 8'hff);
    rd_chk(7'h42, 8'h09);
    idle_pulses(127);
    check(bus_off_out, 1'b1);
    idle_pulses(1);
    check(bus_off_out, 1'b0);
    rd_chk(7'h41, 8'h00);
    poll(7'h10, 8'h80);
    complete_run();
  end
endmodule
